//--- rtl/s2mm_irq_pkg.sv
// Constants and types of the stream-to-memory interrupt status block
package s2mm_irq_pkg;
  // ****************************************
  // Register offsets
  // ****************************************
  localparam int          ADDR_W       = 4;
  localparam logic [3:0]  ADDR_STATUS  = 4'h0;
  localparam logic [3:0]  ADDR_CONTROL = 4'h4;
  // ****************************************
  // Field positions
  // ****************************************
  localparam int          RUN_BIT      = 0;
  localparam int          HALT_BIT     = 0;
  localparam int          RSVD_LO_BIT  = 11;
  localparam int          IOC_BIT      = 12;
  localparam int          DLY_BIT      = 13;
  localparam int          ERR_BIT      = 14;
  localparam int          RSVD_HI_BIT  = 15;
  localparam int          THR_LSB      = 16;
  localparam int          DLYT_LSB     = 24;
  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [2:0]  FLAG_RST     = 3'h0;
  localparam logic [2:0]  EN_RST       = 3'h0;
  localparam logic [7:0]  THR_RST      = 8'h01;
  localparam logic [7:0]  DLYT_RST     = 8'h00;
  localparam logic [31:0] RDATA_RST    = 32'h0000_0000;
  // ****************************************
  // Channel run state
  // ****************************************
  typedef enum logic [1:0] {
    ST_HALTED,
    ST_RUNNING,
    ST_STOPPING
  } run_state_type;
endpackage

//--- rtl/s2mm_irq_status.sv
// Stream-to-memory channel interrupt status, control bits and irq output
// Notes on behaviour
// [RQ1] Bits 11 and 15 ignore writes, read zero
// [RQ2] Chain mode: end-of-frame descriptor sets completion
// [RQ3] Direct mode: finished transfer sets completion
// [RQ4] Completion irq needs enable, and threshold reached in chain mode
// [RQ5] Flags 12-14 reset low, sticky, write-one clears
// [RQ6] Delay expiry sets delay flag, chain mode only
// [RQ7] Delay flag with enable raises irq
// [RQ8] Detected error sets error flag
// [RQ9] Error flag with enable raises irq
// [RQ10] Bits 23:16 show live coalescing countdown
// [RQ11] Before start, count equals threshold; reset 01h
// [RQ12] Bits 31:24 show delay timer, reset 00h
// [RQ13] Error clears run, drains, then sets halted
// [RQ14] Irq is OR of flags gated by enables
//
// Our own choices: the address-and-strobe port and the placing of the registers.
`timescale 1ns/10ps
module s2mm_irq_status
  import s2mm_irq_pkg::*;
(
  // Clock and reset
  input  wire logic                        ref_clk_i,
  input  wire logic                        sys_rst_i,
  // Register port
  input  wire logic [s2mm_irq_pkg::ADDR_W-1:0] addr_i,
  input  wire logic [31:0]                 wdata_i,
  input  wire logic                        wr_i,
  input  wire logic                        rd_i,
  output logic      [31:0]                 rdata_o,
  // Engine events
  input  wire logic                        sg_mode_i,
  input  wire logic                        eof_desc_done_i,
  input  wire logic                        xfer_done_i,
  input  wire logic                        packet_done_i,
  input  wire logic                        delay_expired_i,
  input  wire logic                        error_det_i,
  input  wire logic                        engine_idle_i,
  input  wire logic [7:0]                  delay_timer_i,
  // Channel control and interrupt
  output logic                             run_stop_o,
  output logic                             halted_o,
  output logic                             irq_o
);
  import s2mm_irq_pkg::*;

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    run_state_type st;
    logic [2:0]    flag;
    logic [2:0]    en;
    logic [7:0]    thr;
    logic [7:0]    cnt;
    logic          started;
    logic          met;
    logic [31:0]   rdata;
  } state_type;

  state_type state_r;
  state_type state_nxt;

  logic        wr_stat;
  logic        wr_ctrl;
  logic [2:0]  set_ev;
  logic [2:0]  clr_ev;
  logic [31:0] stat_word;
  logic [31:0] ctrl_word;
  logic        ioc_gate;

  assign wr_stat = wr_i && (addr_i == ADDR_STATUS);
  assign wr_ctrl = wr_i && (addr_i == ADDR_CONTROL);

  // ****************************************
  // Events and readback
  // ****************************************
  always_comb begin
    set_ev[0] = sg_mode_i ? eof_desc_done_i : xfer_done_i;  // RQ2 RQ3
    set_ev[1] = sg_mode_i && delay_expired_i;              // RQ6
    set_ev[2] = error_det_i;                               // RQ8
    clr_ev    = wr_stat ? wdata_i[ERR_BIT:IOC_BIT] : 3'h0;  // RQ5
    // Direct mode has no coalescing, so completion is never held back
    ioc_gate  = state_r.met || !sg_mode_i;                 // RQ4
    stat_word = 32'h0000_0000;                             // RQ1
    stat_word[HALT_BIT] = (state_r.st == ST_HALTED);
    stat_word[IOC_BIT]  = state_r.flag[0];
    stat_word[DLY_BIT]  = state_r.flag[1] && sg_mode_i;
    stat_word[ERR_BIT]  = state_r.flag[2];
    if (sg_mode_i) begin
      stat_word[THR_LSB+:8]  = state_r.cnt;                // RQ10
      stat_word[DLYT_LSB+:8] = delay_timer_i;              // RQ12
    end
    ctrl_word = 32'h0000_0000;
    ctrl_word[RUN_BIT] = (state_r.st == ST_RUNNING);
    ctrl_word[ERR_BIT:IOC_BIT] = state_r.en;
    ctrl_word[THR_LSB+:8] = state_r.thr;
  end

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    state_nxt = state_r;
    // Set wins over a same-cycle clear
    state_nxt.flag = (state_r.flag & ~clr_ev) | set_ev;    // RQ5
    if (clr_ev[0] && !set_ev[0]) begin
      state_nxt.met = 1'b0;
    end
    // Run control
    case (state_r.st)
      ST_HALTED: begin
        if (wr_ctrl && wdata_i[RUN_BIT] && !error_det_i) begin
          state_nxt.st = ST_RUNNING;
        end
      end
      ST_RUNNING: begin
        if (error_det_i || (wr_ctrl && !wdata_i[RUN_BIT])) begin
          state_nxt.st = ST_STOPPING;                      // RQ13
        end
      end
      ST_STOPPING: begin
        if (engine_idle_i) begin
          state_nxt.st = ST_HALTED;                        // RQ13
        end
      end
      default: begin
        state_nxt.st = ST_HALTED;
      end
    endcase
    if (wr_ctrl) begin
      state_nxt.en  = wdata_i[ERR_BIT:IOC_BIT];
      state_nxt.thr = wdata_i[THR_LSB+:8];
    end
    // Coalescing countdown
    if (state_nxt.st == ST_RUNNING) begin
      state_nxt.started = 1'b1;
    end
    if (!state_r.started) begin
      state_nxt.cnt = state_nxt.thr;                       // RQ11
    end
    if (sg_mode_i && packet_done_i) begin
      state_nxt.started = 1'b1;
      if (state_r.cnt <= 8'h01) begin
        state_nxt.cnt = state_nxt.thr;
        state_nxt.met = 1'b1;                              // RQ4
      end else begin
        state_nxt.cnt = state_r.cnt - 8'h01;               // RQ10
      end
    end else if (wr_ctrl) begin
      // A new threshold restarts the countdown
      state_nxt.cnt = wdata_i[THR_LSB+:8];
    end
    // Read data stand for one cycle only
    state_nxt.rdata = 32'h0000_0000;
    if (rd_i) begin
      if (addr_i == ADDR_STATUS) begin
        state_nxt.rdata = stat_word;
      end else if (addr_i == ADDR_CONTROL) begin
        state_nxt.rdata = ctrl_word;
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      state_r.st      <= ST_HALTED;
      state_r.flag    <= FLAG_RST;
      state_r.en      <= EN_RST;
      state_r.thr     <= THR_RST;
      state_r.cnt     <= THR_RST;
      state_r.started <= 1'b0;
      state_r.met     <= 1'b0;
      state_r.rdata   <= RDATA_RST;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign rdata_o    = state_r.rdata;
  assign run_stop_o = (state_r.st == ST_RUNNING);
  assign halted_o   = (state_r.st == ST_HALTED);
  assign irq_o      = (state_r.flag[0] && state_r.en[0] && ioc_gate)  // RQ4 RQ14
                   || (state_r.flag[1] && state_r.en[1] && sg_mode_i)  // RQ7
                   || (state_r.flag[2] && state_r.en[2]);              // RQ9

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);

  property p_rsvd_zero;
    rd_i |=> (rdata_o[RSVD_LO_BIT] == 1'b0) && (rdata_o[RSVD_HI_BIT] == 1'b0);
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved bit set"); // RQ1

  property p_ioc_sg;
    sg_mode_i && eof_desc_done_i |=> state_r.flag[0];
  endproperty
  a_ioc_sg: assert property (p_ioc_sg) else $error("eof did not set flag"); // RQ2

  property p_ioc_dr;
    !sg_mode_i && xfer_done_i |=> state_r.flag[0];
  endproperty
  a_ioc_dr: assert property (p_ioc_dr) else $error("transfer did not set flag"); // RQ3

  property p_ioc_gate;
    irq_o && !(state_r.flag[1] && state_r.en[1]) && !(state_r.flag[2] && state_r.en[2])
      |-> state_r.flag[0] && state_r.en[0] && (state_r.met || !sg_mode_i);
  endproperty
  a_ioc_gate: assert property (p_ioc_gate) else $error("ungated completion irq"); // RQ4

  property p_w1c;
    wr_stat && wdata_i[IOC_BIT] && !set_ev[0] |=> !state_r.flag[0];
  endproperty
  a_w1c: assert property (p_w1c) else $error("write one did not clear"); // RQ5

  property p_sticky;
    state_r.flag[2] && !(wr_stat && wdata_i[ERR_BIT]) |=> state_r.flag[2];
  endproperty
  a_sticky: assert property (p_sticky) else $error("flag lost"); // RQ5

  property p_dly;
    sg_mode_i && delay_expired_i |=> state_r.flag[1];
  endproperty
  a_dly: assert property (p_dly) else $error("delay flag not set"); // RQ6

  property p_dly_irq;
    state_r.flag[1] && state_r.en[1] && sg_mode_i |-> irq_o;
  endproperty
  a_dly_irq: assert property (p_dly_irq) else $error("delay irq missing"); // RQ7

  property p_err;
    error_det_i |=> state_r.flag[2] ##0 !run_stop_o;
  endproperty
  a_err: assert property (p_err) else $error("error not handled"); // RQ8

  property p_err_irq;
    state_r.flag[2] && state_r.en[2] |-> irq_o;
  endproperty
  a_err_irq: assert property (p_err_irq) else $error("error irq missing"); // RQ9

  property p_cnt_dec;
    sg_mode_i && packet_done_i && state_r.started && state_r.cnt > 8'h01
      |=> state_r.cnt == $past(state_r.cnt) - 8'h01;
  endproperty
  a_cnt_dec: assert property (p_cnt_dec) else $error("count not decremented"); // RQ10

  property p_thr_idle;
    !state_r.started |-> state_r.cnt == state_r.thr;
  endproperty
  a_thr_idle: assert property (p_thr_idle) else $error("count differs from threshold"); // RQ11

  property p_dly_read;
    sg_mode_i && rd_i && addr_i == ADDR_STATUS
      |=> rdata_o[DLYT_LSB+:8] == $past(delay_timer_i);
  endproperty
  a_dly_read: assert property (p_dly_read) else $error("delay timer readback"); // RQ12

  property p_halt;
    state_r.st == ST_STOPPING && engine_idle_i |=> halted_o && !run_stop_o;
  endproperty
  a_halt: assert property (p_halt) else $error("halt not reached"); // RQ13

  property p_irq_off;
    state_r.flag == 3'h0 |-> !irq_o;
  endproperty
  a_irq_off: assert property (p_irq_off) else $error("irq without flag"); // RQ14

  property p_dly_chain;
    !sg_mode_i && rd_i && addr_i == ADDR_STATUS |=> rdata_o[DLY_BIT] == 1'b0;
  endproperty
  a_dly_chain: assert property (p_dly_chain) else $error("delay flag in direct mode"); // RQ6

  property p_cnt_chain;
    !sg_mode_i && rd_i && addr_i == ADDR_STATUS
      |=> rdata_o[THR_LSB+:8] == 8'h00 && rdata_o[DLYT_LSB+:8] == 8'h00;
  endproperty
  a_cnt_chain: assert property (p_cnt_chain) else $error("chain field in direct mode"); // RQ10

  property p_reload;
    sg_mode_i && packet_done_i && !wr_ctrl && state_r.cnt <= 8'h01
      |=> state_r.met && state_r.cnt == $past(state_r.thr);
  endproperty
  a_reload: assert property (p_reload) else $error("threshold not reached"); // RQ4

  property p_err_drain;
    run_stop_o && error_det_i |=> !run_stop_o && !halted_o;
  endproperty
  a_err_drain: assert property (p_err_drain) else $error("halted before drain"); // RQ13

  property p_irq_mask;
    irq_o |-> (state_r.flag & state_r.en) != 3'h0;
  endproperty
  a_irq_mask: assert property (p_irq_mask) else $error("irq from masked flag"); // RQ14

  c_completion_irq_flag: cover property (state_r.flag[0] && irq_o);
  c_err_halt: cover property (error_det_i && run_stop_o ##[1:20] halted_o);
  c_reload: cover property (sg_mode_i && packet_done_i && state_r.cnt == 8'h01);
  c_w1c: cover property (irq_o ##1 wr_stat ##1 !irq_o);
  c_direct_ioc: cover property (!sg_mode_i && irq_o);

endmodule

//--- tb/test_s2mm_irq_status.sv
// Self-checking bench for the interrupt status block
`timescale 1ns/10ps
module test_s2mm_irq_status;
  import s2mm_irq_pkg::*;
  // ****************************************
  // Signals
  // ****************************************
  logic                ref_clk_i;
  logic                sys_rst_i;
  logic [ADDR_W-1:0]   addr_i;
  logic [31:0]         wdata_i;
  logic                wr_i;
  logic                rd_i;
  logic [31:0]         rdata_o;
  logic                sg_mode_i;
  logic                engine_idle_i;
  logic [7:0]          delay_timer_i;
  logic [4:0]          ev;
  logic                run_stop_o;
  logic                halted_o;
  logic                irq_o;
  logic                rd_d;
  logic [31:0]         exp_q[$];
  logic [31:0]         rnd;
  logic [7:0]          dly;
  int                  seed = 32'h357c;
  int                  mismatches = 0;
  int                  comparisons = 0;

  s2mm_irq_status s2mm_irq_status_inst (
    .ref_clk_i       (ref_clk_i),
    .sys_rst_i       (sys_rst_i),
    .addr_i          (addr_i),
    .wdata_i         (wdata_i),
    .wr_i            (wr_i),
    .rd_i            (rd_i),
    .rdata_o         (rdata_o),
    .sg_mode_i       (sg_mode_i),
    .eof_desc_done_i (ev[2]),
    .xfer_done_i     (ev[3]),
    .packet_done_i   (ev[4]),
    .delay_expired_i (ev[1]),
    .error_det_i     (ev[0]),
    .engine_idle_i   (engine_idle_i),
    .delay_timer_i   (delay_timer_i),
    .run_stop_o      (run_stop_o),
    .halted_o        (halted_o),
    .irq_o           (irq_o)
  );
  // ****************************************
  // Tasks
  // ****************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test;
    if (mismatches == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge ref_clk_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge ref_clk_i);
    wr_i    <= 1'b0;
  endtask
  // Expected word is queued at the request, compared by the monitor
  task automatic reg_rd(input logic [3:0] a, input logic [31:0] e);
    @(posedge ref_clk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    exp_q.push_back(e);
    @(posedge ref_clk_i);
    rd_i   <= 1'b0;
  endtask
  // Event index: 0 error, 1 delay, 2 eof, 3 direct done, 4 packet
  task automatic pulse(input int k);
    @(posedge ref_clk_i);
    ev[k] <= 1'b1;
    @(posedge ref_clk_i);
    ev    <= 5'h00;
  endtask
  task automatic lvl(input logic seen_sel, input logic e);
    @(negedge ref_clk_i);
    check({31'h0, seen_sel ? halted_o : irq_o}, {31'h0, e});
  endtask
  // ****************************************
  // Clock, monitor, watchdog
  // ****************************************
  initial begin
    ref_clk_i = 1'b0;
    forever #5 ref_clk_i = ~ref_clk_i;
  end
  always @(posedge ref_clk_i) begin
    rd_d <= rd_i;
    if (rd_d === 1'b1) check(rdata_o, exp_q.pop_front());
  end
  initial begin
    repeat (3000) @(posedge ref_clk_i);
    mismatches++;
    end_of_test;
  end
  // ****************************************
  // Scenarios
  // ****************************************
  initial begin
    {addr_i, wdata_i, wr_i, rd_i, ev} = '0;
    {engine_idle_i, delay_timer_i} = '0;
    sg_mode_i = 1'b1;
    sys_rst_i = 1'b1;
    repeat (3) @(posedge ref_clk_i);
    sys_rst_i <= 1'b0;
    reg_rd(4'h0, 32'h0001_0001);
    reg_rd(4'h4, 32'h0001_0000);
    reg_rd(4'h8, 32'h0000_0000);
    reg_wr(4'h4, 32'h0005_0000);
    reg_rd(4'h0, 32'h0005_0001);
    // Error while halted only sets the flag
    reg_wr(4'h4, 32'h0001_4000);
    pulse(0);
    lvl(1'b0, 1'b1);
    reg_rd(4'h0, 32'h0001_4001);
    rnd = $random(seed);
    reg_wr(4'h0, (rnd | 32'h0000_8800) & ~32'h0000_7000);
    reg_rd(4'h0, 32'h0001_4001);
    reg_wr(4'h0, 32'h0000_4000);
    lvl(1'b0, 1'b0);
    // Error while running stops, then halts once drained
    reg_wr(4'h4, 32'h0001_4001);
    @(negedge ref_clk_i);
    check({31'h0, run_stop_o}, 32'h1);
    pulse(0);
    @(negedge ref_clk_i);
    check({31'h0, run_stop_o}, 32'h0);
    lvl(1'b1, 1'b0);
    @(posedge ref_clk_i);
    engine_idle_i <= 1'b1;
    @(posedge ref_clk_i);
    lvl(1'b1, 1'b1);
    reg_wr(4'h0, 32'h0000_4000);
    // Delay expiry with a random live timer value
    rnd = $random(seed);
    dly = rnd[7:0];
    delay_timer_i <= dly;
    reg_wr(4'h4, 32'h0001_2000);
    pulse(1);
    lvl(1'b0, 1'b1);
    reg_rd(4'h0, {dly, 8'h01, 16'h2001});
    reg_wr(4'h0, 32'h0000_2000);
    lvl(1'b0, 1'b0);
    // Coalescing threshold of three packets
    reg_wr(4'h4, 32'h0003_1000);
    pulse(2);
    pulse(4);
    pulse(4);
    lvl(1'b0, 1'b0);
    reg_rd(4'h0, {dly, 8'h01, 16'h1001});
    pulse(4);
    lvl(1'b0, 1'b1);
    reg_wr(4'h0, 32'h0000_1000);
    lvl(1'b0, 1'b0);
    // Direct completion is ignored in chain mode
    pulse(3);
    reg_rd(4'h0, {dly, 8'h03, 16'h0001});
    // Direct mode: chain events ignored, no threshold gating
    @(posedge ref_clk_i);
    sg_mode_i <= 1'b0;
    reg_wr(4'h4, 32'h0001_1000);
    pulse(1);
    pulse(2);
    reg_rd(4'h0, 32'h0000_0001);
    pulse(3);
    lvl(1'b0, 1'b1);
    reg_rd(4'h0, 32'h0000_1001);
    reg_wr(4'h0, 32'h0000_1000);
    lvl(1'b0, 1'b0);
    // Masked completion keeps the output low
    reg_wr(4'h4, 32'h0001_0000);
    pulse(3);
    lvl(1'b0, 1'b0);
    reg_rd(4'h0, 32'h0000_1001);
    repeat (3) @(posedge ref_clk_i);
    end_of_test;
  end
endmodule
